// file: logic/pts_map.svh
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH

// register offsets
`define PTS_OFS_FLAGS       8'h0C
`define PTS_OFS_COUNT       8'h11
`define PTS_OFS_CONTROL     8'h12
`define PTS_OFS_ENABLES     8'h8C
`define PTS_OFS_PERIOD      8'h92

// reset values
`define PTS_RST_COUNT       8'h00
`define PTS_RST_CONTROL     7'h00
`define PTS_RST_PERIOD      8'hFF

// field positions
`define PTS_BIT_MATCH_FLAG  1
`define PTS_BIT_RUN         2
`define PTS_CKPS_LSB        0
`define PTS_CKPS_MSB        1
`define PTS_OUTPS_LSB       3
`define PTS_OUTPS_MSB       6

// timing: oscillator clocks per instruction clock, prescaler terminal counts
`define PTS_OSC_PER_INSTR   4
`define PTS_PRE_TERM_1      4'h0
`define PTS_PRE_TERM_4      4'h3
`define PTS_PRE_TERM_16     4'hF

`endif

// file: logic/pts_pkg.sv
`default_nettype none
package pts_pkg;

  // instruction clock phases, gray coded so one bit moves per clock
  typedef enum logic [1:0] {
    PTS_PH_Q1 = 2'b00,
    PTS_PH_Q2 = 2'b01,
    PTS_PH_Q3 = 2'b11,
    PTS_PH_Q4 = 2'b10
  } pts_phase_t;

  typedef logic [7:0] pts_byte_t;

endpackage
`default_nettype wire

// file: logic/pts_scl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pts_scl_if;
  logic       instr_tick;
  logic       run;
  logic       clr;
  logic [1:0] ckps;
  logic [3:0] outps;
  logic       match;
  logic       inc_tick;
  logic       post_tick;

  modport core (
    output instr_tick,
    output run,
    output clr,
    output ckps,
    output outps,
    output match,
    input  inc_tick,
    input  post_tick
  );

  modport scaler (
    input  instr_tick,
    input  run,
    input  clr,
    input  ckps,
    input  outps,
    input  match,
    output inc_tick,
    output post_tick
  );
endinterface
`default_nettype wire

// file: logic/pts_scaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "pts_map.svh"
module pts_scaler
  import pts_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  pts_scl_if.scaler s
);

  logic [3:0] pre_cnt_r;
  logic [3:0] pre_cnt_nxt;
  logic [3:0] post_cnt_r;
  logic [3:0] post_cnt_nxt;
  wire  [3:0] pre_term;
  wire        pre_hit;
  wire        pre_step;
  wire        post_hit;

  // 1x selects sixteen whatever the low bit holds
  assign pre_term = s.ckps[1] ? `PTS_PRE_TERM_16 :
                    (s.ckps[0] ? `PTS_PRE_TERM_4 : `PTS_PRE_TERM_1); // RQ3
  assign pre_step = s.instr_tick & s.run; // RQ8
  assign pre_hit  = pre_cnt_r == pre_term;
  assign s.inc_tick = pre_step & pre_hit; // RQ2

  // postscale is select plus one
  assign post_hit  = post_cnt_r == s.outps; // RQ7
  assign s.post_tick = s.match & post_hit; // RQ6

  assign pre_cnt_nxt  = s.clr ? 4'h0 :
                        (pre_step ? (pre_hit ? 4'h0 : pre_cnt_r + 4'h1) : pre_cnt_r); // RQ9 RQ10
  assign post_cnt_nxt = s.clr ? 4'h0 :
                        (s.match ? (post_hit ? 4'h0 : post_cnt_r + 4'h1) : post_cnt_r);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_r  <= 4'h0; // RQ11
      post_cnt_r <= 4'h0; // RQ11
    end else begin
      pre_cnt_r  <= pre_cnt_nxt;
      post_cnt_r <= post_cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// file: logic/pts_timer.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pts_map.svh"
// Operation
// RQ1 - count register readable, writable, reset zero
// RQ2 - input is instruction clock via prescaler
// RQ3 - divide select: 00 one, 01 four, 1x sixteen
// RQ4 - count up to period, then wrap, pulse
// RQ5 - period register read/write, resets to all ones
// RQ6 - postscaler output latches match event flag
// RQ7 - postscale ratio is select value plus one
// RQ8 - count only while run bit set
// RQ9 - count write clears both scaler counters
// RQ10 - control write clears both scaler counters
// RQ11 - every reset clears both scaler counters
// RQ12 - control write keeps count value
// RQ13 - unscaled match pulse goes to serial port
// RQ14 - count and match feed pwm time base
// RQ15 - control bit seven reads zero, reset zero
// RQ16 - flag sticky; interrupt when flag and enable
// RQ17 - control settings act next instruction cycle
module pts_timer
  import pts_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            irq,
  output logic            ssp_match_pulse,
  output logic      [7:0] pwm_count,
  output logic      [7:0] pwm_period,
  output logic            pwm_match
);

  pts_scl_if scl ();

  pts_phase_t phase_r;
  pts_phase_t phase_nxt;
  pts_byte_t  count_r;
  pts_byte_t  count_nxt;
  pts_byte_t  period_r;
  logic [6:0] control_r;
  logic       flag_r;
  logic       flag_nxt;
  logic       enable_r;
  logic       match_r;
  pts_byte_t  rdata_r;
  pts_byte_t  rdata_nxt;

  wire        sel_flags;
  wire        sel_count;
  wire        sel_control;
  wire        sel_enables;
  wire        sel_period;
  wire        wr_count;
  wire        wr_control;
  wire        wr_enables;
  wire        wr_period;
  wire        rd_flags;
  wire        at_period;
  wire        match_now;
  pts_byte_t  flags_view;
  pts_byte_t  enables_view;
  pts_byte_t  control_view;
  pts_byte_t  read_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction

  function automatic pts_byte_t bit_at(input logic v, input int pos);
    pts_byte_t b;
    b = 8'h00;
    b[pos[2:0]] = v;
    bit_at = b;
  endfunction

  // address decode
  assign sel_flags   = hit(addr, `PTS_OFS_FLAGS);
  assign sel_count   = hit(addr, `PTS_OFS_COUNT);
  assign sel_control = hit(addr, `PTS_OFS_CONTROL);
  assign sel_enables = hit(addr, `PTS_OFS_ENABLES);
  assign sel_period  = hit(addr, `PTS_OFS_PERIOD);

  assign wr_count   = wr & sel_count;
  assign wr_control = wr & sel_control;
  assign wr_enables = wr & sel_enables;
  assign wr_period  = wr & sel_period;
  assign rd_flags   = rd & sel_flags;

  // instruction clock: one enable pulse every fourth oscillator clock
  always_comb begin
    case (phase_r)
      PTS_PH_Q1: phase_nxt = PTS_PH_Q2;
      PTS_PH_Q2: phase_nxt = PTS_PH_Q3;
      PTS_PH_Q3: phase_nxt = PTS_PH_Q4;
      PTS_PH_Q4: phase_nxt = PTS_PH_Q1;
      default:   phase_nxt = PTS_PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= PTS_PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // scaler hookup; settings come straight from the control flops, so a
  // write lands one clock later and the next instruction tick sees it
  assign scl.instr_tick = phase_r == PTS_PH_Q4; // RQ2
  assign scl.run        = control_r[`PTS_BIT_RUN]; // RQ8 RQ17
  assign scl.ckps       = control_r[`PTS_CKPS_MSB:`PTS_CKPS_LSB]; // RQ17
  assign scl.outps      = control_r[`PTS_OUTPS_MSB:`PTS_OUTPS_LSB]; // RQ17
  assign scl.clr        = wr_count | wr_control; // RQ9 RQ10
  assign scl.match      = match_now;

  pts_scaler u_scaler (
    .clk  (clk),
    .nrst (nrst),
    .s    (scl.scaler)
  );

  // counter; a software write beats a coincident increment
  assign at_period = count_r == period_r;
  assign match_now = scl.inc_tick & at_period & ~wr_count; // RQ4

  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = wdata; // RQ1
    end else if (scl.inc_tick) begin
      if (at_period) begin
        count_nxt = 8'h00; // RQ4
      end else begin
        count_nxt = count_r + 8'h01; // RQ4
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= `PTS_RST_COUNT; // RQ1
      match_r <= 1'b0;
    end else begin
      count_r <= count_nxt; // RQ12
      match_r <= match_now;
    end
  end

  // period and control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      period_r  <= `PTS_RST_PERIOD; // RQ5
      control_r <= `PTS_RST_CONTROL; // RQ15
    end else begin
      if (wr_period) begin
        period_r <= wdata; // RQ5
      end
      if (wr_control) begin
        control_r <= wdata[6:0]; // RQ15
      end
    end
  end

  // sticky flag: reading the flags clears it, but a new event wins
  assign flag_nxt = scl.post_tick | (flag_r & ~rd_flags); // RQ6 RQ16

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_r   <= 1'b0;
      enable_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt; // RQ16
      if (wr_enables) begin
        enable_r <= wdata[`PTS_BIT_MATCH_FLAG];
      end
    end
  end

  assign irq = flag_r & enable_r; // RQ16

  // read path; unmapped addresses and idle cycles return zero
  assign flags_view   = bit_at(flag_r, `PTS_BIT_MATCH_FLAG);
  assign enables_view = bit_at(enable_r, `PTS_BIT_MATCH_FLAG);
  assign control_view = {1'b0, control_r}; // RQ15

  assign read_mux = sel_flags   ? flags_view   :
                    sel_count   ? count_r      :
                    sel_control ? control_view :
                    sel_enables ? enables_view :
                    sel_period  ? period_r     : 8'h00;

  assign rdata_nxt = rd ? read_mux : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // consumers outside: the serial port takes the unscaled match, the
  // pwm unit takes count, period and the same match
  assign ssp_match_pulse = match_r; // RQ13
  assign pwm_count       = count_r; // RQ14
  assign pwm_period      = period_r; // RQ14
  assign pwm_match       = match_r; // RQ14

endmodule
`default_nettype wire

// file: bench/pts_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pts_timer_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       ssp_match_pulse,
  input wire logic [7:0] pwm_count,
  input wire logic [7:0] pwm_period,
  input wire logic       pwm_match
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // one count step per instruction clock at most; a write may move it sooner
  sequence quiet_s;
    ($stable(pwm_count) || $past(wr)) [*3];
  endsequence
  rd_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  count_step_a: assert property ($changed(pwm_count) && !$past(wr) |=> quiet_s)
    else $error("count stepped too fast");
  match_pulse_a: assert property (ssp_match_pulse |=> !ssp_match_pulse)
    else $error("match pulse too long");
  pwm_match_a: assert property (pwm_match == ssp_match_pulse)
    else $error("pwm match differs");
  count_wr_a: assert property (wr && addr == 8'h11 |=> pwm_count == $past(wdata))
    else $error("count write lost");
  period_wr_a: assert property (wr && addr == 8'h92 |=> pwm_period == $past(wdata))
    else $error("period write lost");
  wrap_zero_a: assert property (ssp_match_pulse && !$past(wr) |-> pwm_count == 8'h00)
    else $error("count not zero at match");
  flag_clr_a: assert property (rd && addr == 8'h0c |=> !irq || ssp_match_pulse)
    else $error("flag read did not clear");
  irq_fall_a: assert property ($fell(irq) |-> $past(rd && addr == 8'h0c) || $past(wr))
    else $error("irq dropped by itself");
endmodule
`default_nettype wire

// file: bench/tb_pts_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pts_timer;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} pts_row_t;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata, cnt, per;
  logic       irq, smp;
  int         fail_count = 0;
  int         checks = 0;
  int         n;
  int         dv [4] = '{1, 4, 16, 16};
  pts_row_t   rows [11] = '{'{0, 8'h11, 0, 8'h00}, '{0, 8'h12, 0, 8'h00},
    '{0, 8'h92, 0, 8'hff}, '{0, 8'h0c, 0, 8'h00}, '{0, 8'h8c, 0, 8'h00},
    '{1, 8'h11, 8'h5a, 8'h5a}, '{1, 8'h92, 8'h3c, 8'h3c}, '{1, 8'h12, 8'hfb, 8'h7b},
    '{0, 8'h11, 0, 8'h5a}, '{1, 8'h8c, 8'hff, 8'h02}, '{1, 8'h0c, 8'hff, 8'h00}};
  always #2.5 clk = ~clk;
  pts_timer dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .ssp_match_pulse(smp), .pwm_count(cnt), .pwm_period(per),
    .pwm_match());
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // edges until the count moves; the free phase divider adds up to three clocks
  task automatic gap(output int k);
    logic [7:0] c;
    k = 0;
    c = cnt;
    while (cnt === c && k < 300) begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  // match pulses seen until the interrupt rises; bounded so a dead flag cannot hang
  task automatic pulses(output int p);
    p = 0;
    for (int k = 0; k < 400 && irq !== 1'b1; k++) begin
      @(posedge clk);
      #1 p += int'(smp);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, rows[i].e);
    end
    wreg(8'h92, 8'hff);
    foreach (dv[i]) begin
      wreg(8'h12, 8'h04 | 8'(i));
      gap(n);
      chk(8'(n > 4 * dv[i] - 4 && n <= 4 * dv[i]), 8'h01);
      gap(n);
      chk(8'(n), 8'(4 * dv[i]));
    end
    for (int i = 0; i < 2; i++) begin
      repeat (30) @(posedge clk);
      wreg(i ? 8'h12 : 8'h11, i ? 8'h07 : 8'h10);
      gap(n);
      chk(8'(n > 60 && n < 65), 8'h01);
    end
    wreg(8'h92, 8'h00);
    wreg(8'h11, 8'h00);
    wreg(8'h8c, 8'h02);
    for (int i = 0; i < 16; i++) begin
      wreg(8'h12, 8'h00);
      rreg(8'h0c, i ? 8'h02 : 8'h00);
      chk({7'h00, irq}, 8'h00);
      wreg(8'h12, {1'b0, 4'(i), 3'b100});
      pulses(n);
      chk(8'(n), 8'(i + 1));
    end
    wreg(8'h8c, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rreg(8'h0c, 8'h02);
    // postscaler left at two of four, then a count write must restart it
    wreg(8'h8c, 8'h02);
    wreg(8'h12, 8'h1c);
    repeat (2) @(posedge smp);
    wreg(8'h11, 8'h00);
    pulses(n);
    chk(8'(n), 8'h04);
    wreg(8'h92, 8'h80);
    wreg(8'h11, 8'h44);
    @(posedge clk);
    nrst <= 1'b0;
    #1 chk(cnt, 8'h00);
    chk(per, 8'hff);
    @(posedge clk);
    nrst <= 1'b1;
    rreg(8'h12, 8'h00);
    complete_run;
  end
endmodule
bind pts_timer pts_timer_chk u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .ssp_match_pulse(ssp_match_pulse),
  .pwm_count(pwm_count), .pwm_period(pwm_period), .pwm_match(pwm_match));
`default_nettype wire
